// file: src/uts_pkg.sv
/*
 * Shared constants and types of the serial port with its baud timer.
 * Assumes an 8-bit register port and a 4-bit register address.
 */
package uts_pkg;

	// Register offsets.
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_DATA = 4'h1;
	localparam logic [3:0] A_RELOAD = 4'h2;
	localparam logic [3:0] A_LOW = 4'h3;
	localparam logic [3:0] A_TCFG = 4'h4;
	localparam logic [3:0] A_STAT = 4'h5;
	localparam logic [3:0] A_MASK = 4'h6;

	// Field positions of serial_control_reg.
	localparam int B_MODE = 7;
	localparam int B_MCE = 5;
	localparam int B_REN = 4;
	localparam int B_TB8 = 3;
	localparam int B_RB8 = 2;
	localparam int B_TI = 1;
	localparam int B_RI = 0;

	// Field positions of the timer setup, status and mask registers.
	localparam int B_RUN = 0;
	localparam int B_SEL = 1;
	localparam int S_RX = 0;
	localparam int S_TX = 1;
	localparam int S_OVR = 2;
	localparam int N_STAT = 3;

	// Reset values.
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [2:0] MASK_RST = 3'h0;

	// Frame lengths and clock divider end counts.
	localparam logic [3:0] FRAME8 = 4'ha;
	localparam logic [3:0] FRAME9 = 4'hb;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [1:0] DIV48_LAST = 2'h3;
	localparam logic [2:0] OSC8_LAST = 3'h7;

	typedef enum logic [2:0] {
		CS_SYS = 3'h0,
		CS_DIV4 = 3'h1,
		CS_DIV12 = 3'h2,
		CS_DIV48 = 3'h3,
		CS_OSC8 = 3'h4,
		CS_PIN = 3'h5
	} uts_clksel_t;

	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} uts_rx_state_t;

endpackage

// file: src/uts_baud_if.sv
/*
 * Signals between the port's register side and its baud timer.
 * Assumes both ends run on the one system clock.
 */
interface uts_baud_if;
	logic run;
	logic [2:0] sel;
	logic [7:0] reload;
	logic low_wr;
	logic [7:0] low_wdata;
	logic [7:0] low;
	logic tx_bit;
	logic rx_ovf;
	logic rx_restart;

	modport gen (input run, sel, reload, low_wr, low_wdata, rx_restart,
		output low, tx_bit, rx_ovf);
	modport user (output run, sel, reload, low_wr, low_wdata, rx_restart,
		input low, tx_bit, rx_ovf);
endinterface

// file: src/uts_baud.sv
/*
 * Baud timer: clock prescaler, transmit timer, hidden receive timer.
 * Assumes external oscillator and timer pin are synchronous levels.
 */
module uts_baud (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ext_osc,
	input wire logic i_ext_pin,
	uts_baud_if.gen bif
);
	logic [1:0] c4_r;
	logic [3:0] c12_r;
	logic [1:0] q48_r;
	logic osc_q_r;
	logic pin_q_r;
	logic [2:0] osc_cnt_r;
	logic [7:0] tx_low_r;
	logic [7:0] rx_low_r;
	logic tx_half_r;
	logic tx_bit_r;
	logic rx_ovf_r;

	wire t4 = c4_r == uts_pkg::DIV4_LAST;
	wire t12 = c12_r == uts_pkg::DIV12_LAST;
	wire t48 = t12 && q48_r == uts_pkg::DIV48_LAST;
	wire osc_rise = i_ext_osc && !osc_q_r;
	wire t_osc = osc_rise && osc_cnt_r == uts_pkg::OSC8_LAST;
	wire t_pin = pin_q_r && !i_ext_pin;
	// The source choice only gates a tick; the timer itself never changes clock.
	wire tick = (bif.sel == uts_pkg::CS_SYS) || (bif.sel == uts_pkg::CS_DIV4 && t4)
		|| (bif.sel == uts_pkg::CS_DIV12 && t12) || (bif.sel == uts_pkg::CS_DIV48 && t48)
		|| (bif.sel == uts_pkg::CS_OSC8 && t_osc) || (bif.sel == uts_pkg::CS_PIN && t_pin);
	wire step = bif.run && tick;
	wire tx_ovf = step && tx_low_r == 8'hff;
	wire rx_ovf = step && rx_low_r == 8'hff;
	wire [7:0] tx_low_nxt = tx_ovf ? bif.reload : 8'(tx_low_r + 8'h01);
	wire [7:0] rx_low_nxt = rx_ovf ? bif.reload : 8'(rx_low_r + 8'h01);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			c4_r <= 2'h0;
			c12_r <= 4'h0;
			q48_r <= 2'h0;
			osc_q_r <= 1'b0;
			pin_q_r <= 1'b0;
			osc_cnt_r <= 3'h0;
		end else begin
			c4_r <= 2'(c4_r + 2'h1);
			c12_r <= t12 ? 4'h0 : 4'(c12_r + 4'h1);
			q48_r <= t12 ? 2'(q48_r + 2'h1) : q48_r;
			osc_q_r <= i_ext_osc;
			pin_q_r <= i_ext_pin;
			osc_cnt_r <= osc_rise ? 3'(osc_cnt_r + 3'h1) : osc_cnt_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_low_r <= 8'h00;
			rx_low_r <= 8'h00;
			tx_half_r <= 1'b0;
			tx_bit_r <= 1'b0;
			rx_ovf_r <= 1'b0;
		end else begin
			tx_low_r <= bif.low_wr ? bif.low_wdata : (step ? tx_low_nxt : tx_low_r); // see R7
			rx_low_r <= bif.rx_restart ? bif.reload : (step ? rx_low_nxt : rx_low_r); // see R8, R10
			tx_half_r <= tx_ovf ? !tx_half_r : tx_half_r; // see R9
			tx_bit_r <= tx_ovf && tx_half_r; // see R9
			rx_ovf_r <= rx_ovf && !bif.rx_restart;
		end
	end

	assign bif.low = tx_low_r;
	assign bif.tx_bit = tx_bit_r;
	assign bif.rx_ovf = rx_ovf_r;

	a_rx_reload_start: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R10
		bif.rx_restart |=> rx_low_r == $past(bif.reload))
		else $error("Receive timer missed its reload on a start edge.");

	a_tx_rate_halved: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R9
		tx_bit_r |=> !tx_bit_r)
		else $error("Transmit bit pulse came on two overflows in a row.");
endmodule

// file: src/uts_rx.sv
/*
 * Receive shifter: finds the start edge, samples mid-bit, frames a byte.
 * Assumes the receive pin is synchronous and i_ovf is the receive timer overflow.
 */
module uts_rx (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_rxd,
	input wire logic i_en,
	input wire logic i_nine,
	input wire logic i_ovf,
	output logic o_restart,
	output logic o_done,
	output logic [7:0] o_data,
	output logic o_bit9
);
	uts_pkg::uts_rx_state_t st_r, st_nxt;
	logic prev_r;
	logic half_r;
	logic [3:0] cnt_r;
	logic [8:0] sh_r;

	wire idle = st_r == uts_pkg::RX_IDLE;
	wire start_seen = idle && i_en && prev_r && !i_rxd;
	wire ovf = i_ovf && !o_restart;
	// Two overflows make one bit; the first after the start edge lands mid-bit.
	wire samp = ovf && half_r;
	wire last = cnt_r == (i_nine ? 4'h8 : 4'h7);
	wire in_frame = st_r == uts_pkg::RX_DATA || st_r == uts_pkg::RX_STOP;
	wire stop_samp = st_r == uts_pkg::RX_STOP && samp;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			uts_pkg::RX_IDLE: st_nxt = start_seen ? uts_pkg::RX_START : st_r;
			uts_pkg::RX_START: begin
				if (ovf) begin
					st_nxt = i_rxd ? uts_pkg::RX_IDLE : uts_pkg::RX_DATA;
				end
			end
			uts_pkg::RX_DATA: st_nxt = (samp && last) ? uts_pkg::RX_STOP : st_r;
			uts_pkg::RX_STOP: st_nxt = samp ? uts_pkg::RX_IDLE : st_r;
			default: st_nxt = uts_pkg::RX_IDLE;
		endcase
		if (!i_en) begin
			st_nxt = uts_pkg::RX_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= uts_pkg::RX_IDLE;
			prev_r <= 1'b1;
			half_r <= 1'b0;
			cnt_r <= 4'h0;
			sh_r <= 9'h000;
		end else begin
			st_r <= st_nxt;
			prev_r <= i_rxd;
			half_r <= in_frame ? (half_r ^ ovf) : 1'b0; // see R9
			cnt_r <= (st_r == uts_pkg::RX_DATA) ? 4'(cnt_r + {3'h0, samp}) : 4'h0;
			sh_r <= (st_r == uts_pkg::RX_DATA && samp) ? {i_rxd, sh_r[8:1]} : sh_r; // see R14
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_restart <= 1'b0;
			o_done <= 1'b0;
			o_data <= 8'h00;
			o_bit9 <= 1'b0;
		end else begin
			o_restart <= start_seen; // see R10
			o_done <= stop_samp;
			o_data <= stop_samp ? (i_nine ? sh_r[7:0] : sh_r[8:1]) : o_data;
			o_bit9 <= stop_samp ? (i_nine ? sh_r[8] : i_rxd) : o_bit9; // see R14, R15
		end
	end
endmodule

// file: src/uts_top.sv
/*
 * Full-duplex serial port with baud timer and a plain register port.
 * Assumes a synchronous register master and synchronous serial and timer pins.
 */
// Overview of operation
// R1: Full duplex, eight and nine bit frames only.
// R2: Receiver keeps a buffer while shifting next byte.
// R3: Data write loads transmitter, starts a frame.
// R4: Data read returns receive buffer, never transmitter.
// R5: Interrupt on transmit done or receive done.
// R6: Software alone clears the done flags.
// R7: Transmit timing from auto-reload low count overflows.
// R8: Hidden receive counter shares the reload byte.
// R9: Each overflow rate divided by two.
// R10: Start edge forces receive timer reload.
// R11: Six selectable baud timer clock sources.
// R12: Software reloads for twice the bit rate.
// R13: External oscillator feeds timer, system clock unchanged.
// R14: Eight bit frame: start, data LSB first, stop.
// R15: Nine bit frame carries programmable ninth bit.
// R16: Load only when receive flag clear, filter.
// R17: Transmit done set as stop bit begins.
// R18: Interrupt is enabled OR of both flags and the status bits.
module uts_top (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_rxd,
	output logic o_txd,
	input wire logic i_ext_osc,
	input wire logic i_baud_ext_input_pin,
	output logic o_irq
);
	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	wire rst_n = rst_sync_r;

	logic mode_r;
	logic mce_r;
	logic ren_r;
	logic tb8_r;
	logic rb8_r;
	logic ti_r;
	logic ri_r;
	logic [7:0] rbuf_r;
	logic [7:0] reload_r;
	logic run_r;
	uts_pkg::uts_clksel_t sel_r;
	logic [2:0] stat_r;
	logic [2:0] mask_r;
	logic [10:0] tx_sh_r;
	logic [3:0] tx_cnt_r;

	logic rx_restart;
	logic rx_done;
	logic [7:0] rx_data;
	logic rx_bit9;

	uts_baud_if bif ();

	// Register decode.
	wire wr_ctrl = i_wr && i_addr == uts_pkg::A_CTRL;
	wire wr_data = i_wr && i_addr == uts_pkg::A_DATA;
	wire wr_reload = i_wr && i_addr == uts_pkg::A_RELOAD;
	wire wr_low = i_wr && i_addr == uts_pkg::A_LOW;
	wire wr_tcfg = i_wr && i_addr == uts_pkg::A_TCFG;
	wire wr_mask = i_wr && i_addr == uts_pkg::A_MASK;
	wire rd_stat = i_rd && i_addr == uts_pkg::A_STAT;

	wire [7:0] ctrl_view = {mode_r, 1'b1, mce_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
	wire [7:0] tcfg_view = {4'h0, sel_r, run_r};

	// Unmapped offsets read as zero.
	wire [7:0] rd_mux =
		(i_addr == uts_pkg::A_CTRL) ? ctrl_view :
		(i_addr == uts_pkg::A_DATA) ? rbuf_r :
		(i_addr == uts_pkg::A_RELOAD) ? reload_r :
		(i_addr == uts_pkg::A_LOW) ? bif.low :
		(i_addr == uts_pkg::A_TCFG) ? tcfg_view :
		(i_addr == uts_pkg::A_STAT) ? {5'h00, stat_r} :
		(i_addr == uts_pkg::A_MASK) ? {5'h00, mask_r} :
		8'h00;

	// Receive acceptance.
	wire rx_ok = rx_done && !ri_r && (!mce_r || rx_bit9);
	wire rx_lost = rx_done && ri_r;

	// Transmit frame build and shift.
	wire [3:0] tx_full = mode_r ? uts_pkg::FRAME9 : uts_pkg::FRAME8;
	wire [10:0] tx_frame = {1'b1, mode_r ? tb8_r : 1'b1, i_wdata, 1'b0};
	wire tx_step = bif.tx_bit && tx_cnt_r != 4'h0;
	wire ti_set = tx_step && tx_cnt_r == 4'h1 && !wr_data;

	// Next values of the flags; a hardware set beats a software clear.
	wire ti_nxt = ti_set || (wr_ctrl ? i_wdata[uts_pkg::B_TI] : ti_r);
	wire ri_nxt = rx_ok || (wr_ctrl ? i_wdata[uts_pkg::B_RI] : ri_r);
	wire rb8_nxt = rx_ok ? rx_bit9 : (wr_ctrl ? i_wdata[uts_pkg::B_RB8] : rb8_r);
	wire [7:0] rbuf_nxt = rx_ok ? rx_data : rbuf_r;

	wire [2:0] stat_ev = {rx_lost, ti_set, rx_ok};
	wire [2:0] stat_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < uts_pkg::N_STAT; gi++) begin : g_stat
			assign stat_nxt[gi] = stat_ev[gi] || (!rd_stat && stat_r[gi]);
		end
	endgenerate

	wire irq_nxt = |(stat_r & mask_r)
		|| (ti_r && mask_r[uts_pkg::S_TX])
		|| (ri_r && mask_r[uts_pkg::S_RX]);

	// Baud timer wiring.
	assign bif.run = run_r;
	assign bif.sel = sel_r;
	assign bif.reload = reload_r;
	assign bif.low_wr = wr_low;
	assign bif.low_wdata = i_wdata;
	assign bif.rx_restart = rx_restart;

	uts_baud u_baud (
		.i_clk(i_clk_sys),
		.i_rst_n(rst_n),
		.i_ext_osc(i_ext_osc),
		.i_ext_pin(i_baud_ext_input_pin),
		.bif(bif)
	);

	uts_rx u_rx (
		.i_clk(i_clk_sys),
		.i_rst_n(rst_n),
		.i_rxd(i_rxd),
		.i_en(ren_r),
		.i_nine(mode_r),
		.i_ovf(bif.rx_ovf),
		.o_restart(rx_restart),
		.o_done(rx_done),
		.o_data(rx_data),
		.o_bit9(rx_bit9)
	);

	// Control register.
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= 1'b0;
			mce_r <= 1'b0;
			ren_r <= 1'b0;
			tb8_r <= 1'b0;
		end else if (wr_ctrl) begin
			mode_r <= i_wdata[uts_pkg::B_MODE]; // see R1
			mce_r <= i_wdata[uts_pkg::B_MCE];
			ren_r <= i_wdata[uts_pkg::B_REN];
			tb8_r <= i_wdata[uts_pkg::B_TB8];
		end
	end

	// Flags and receive buffer.
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ti_r <= 1'b0;
			ri_r <= 1'b0;
			rb8_r <= 1'b0;
			rbuf_r <= 8'h00;
		end else begin
			ti_r <= ti_nxt; // see R6, R17
			ri_r <= ri_nxt; // see R6, R16
			rb8_r <= rb8_nxt; // see R15
			rbuf_r <= rbuf_nxt; // see R2, R16
		end
	end

	// Timer setup.
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reload_r <= uts_pkg::RELOAD_RST;
			run_r <= 1'b0;
			sel_r <= uts_pkg::CS_SYS;
		end else begin
			reload_r <= wr_reload ? i_wdata : reload_r; // see R8
			run_r <= wr_tcfg ? i_wdata[uts_pkg::B_RUN] : run_r;
			if (wr_tcfg) begin
				sel_r <= uts_pkg::uts_clksel_t'(i_wdata[uts_pkg::B_SEL +: 3]); // see R11, R13
			end
		end
	end

	// Status, mask, interrupt and read port.
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= 3'h0;
			mask_r <= uts_pkg::MASK_RST;
			o_irq <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			stat_r <= stat_nxt;
			mask_r <= wr_mask ? i_wdata[2:0] : mask_r;
			o_irq <= irq_nxt; // see R5, R18
			o_rdata <= i_rd ? rd_mux : 8'h00; // see R4
		end
	end

	// Transmitter. A write mid-frame restarts it with the new byte.
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh_r <= 11'h7ff;
			tx_cnt_r <= 4'h0;
			o_txd <= 1'b1;
		end else if (wr_data) begin
			tx_sh_r <= tx_frame; // see R3, R15
			tx_cnt_r <= tx_full;
			o_txd <= 1'b1;
		end else if (tx_step) begin
			o_txd <= tx_sh_r[0]; // see R14
			tx_sh_r <= {1'b1, tx_sh_r[10:1]};
			tx_cnt_r <= 4'(tx_cnt_r - 4'h1);
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_data_write;
		wr_data;
	endsequence

	sequence s_first_tick;
		bif.tx_bit && !wr_data && tx_cnt_r == tx_full && tx_sh_r[0] == 1'b0;
	endsequence

	sequence s_last_tick;
		tx_step && !wr_data && tx_cnt_r == 4'h1;
	endsequence

	sequence s_rx_off;
		!ren_r ##1 !ren_r;
	endsequence

	a_write_starts_tx: assert property (s_data_write |=> tx_cnt_r == $past(tx_full)) // see R3
		else $error("Data write did not load a full frame.");

	a_write_keeps_rx: assert property (s_data_write and !rx_ok |=> $stable(rbuf_r)) // see R3
		else $error("Data write altered the receive buffer.");

	a_read_rx_buf: assert property ( // see R4
		i_rd && i_addr == uts_pkg::A_DATA |=> o_rdata == $past(rbuf_r))
		else $error("Data read did not return the receive buffer.");

	a_start_bit_low: assert property (s_first_tick |=> !o_txd ##0 tx_cnt_r == $past(tx_full) - 4'h1) // see R14
		else $error("First bit of a frame was not a low start bit.");

	a_ti_at_stop: assert property ($rose(ti_r) && !$past(wr_ctrl) |-> o_txd && tx_cnt_r == 4'h0) // see R17
		else $error("Transmit done rose away from the stop bit start.");

	a_flag_holds: assert property (ti_r && ri_r && !wr_ctrl |=> ti_r && ri_r) // see R6
		else $error("A done flag cleared without a software write.");

	a_rx_loads_buf: assert property (rx_ok |=> rbuf_r == $past(rx_data) && ri_r) // see R2
		else $error("Accepted byte did not reach the receive buffer.");

	a_rx_no_overrun: assert property (rx_done && ri_r |=> $stable(rbuf_r) && stat_r[uts_pkg::S_OVR]) // see R16
		else $error("Receive buffer overwritten while its flag was set.");

	a_mce_filter: assert property ( // see R16
		rx_done && mce_r && !rx_bit9 && !wr_ctrl |=> ri_r == $past(ri_r))
		else $error("Multiprocessor filter let a frame through.");

	a_irq_follows: assert property ( // see R18
		(ti_r && mask_r[uts_pkg::S_TX]) || (ri_r && mask_r[uts_pkg::S_RX]) |=> o_irq)
		else $error("Interrupt low while an enabled flag was set.");

	a_irq_quiet: assert property ( // see R5
		!ti_r && !ri_r && stat_r == 3'h0 |=> !o_irq)
		else $error("Interrupt high with no flag or status set.");

	a_ti_set_wins: assert property (ti_set |=> ti_r) // see R6
		else $error("Transmit done lost against a same cycle write.");

	a_ti_sw_clear: assert property ( // see R6
		wr_ctrl && !i_wdata[uts_pkg::B_TI] && !ti_set |=> !ti_r)
		else $error("Software clear of transmit done had no effect.");

	a_ri_sw_clear: assert property ( // see R6
		wr_ctrl && !i_wdata[uts_pkg::B_RI] && !rx_ok |=> !ri_r)
		else $error("Software clear of receive done had no effect.");

	a_ti_no_cause: assert property (!ti_r && !ti_set && !wr_ctrl |=> !ti_r) // see R17
		else $error("Transmit done rose with no frame end.");

	a_ri_no_cause: assert property (!ri_r && !rx_ok && !wr_ctrl |=> !ri_r) // see R16
		else $error("Receive done rose with no accepted frame.");

	a_rb8_from_rx: assert property (rx_ok |=> rb8_r == $past(rx_bit9)) // see R15
		else $error("Received ninth bit was not stored.");

	a_line_idle_high: assert property (tx_cnt_r == 4'h0 |-> o_txd) // see R14
		else $error("Transmit line low outside a frame.");

	a_write_line_high: assert property (s_data_write |=> o_txd) // see R3
		else $error("Data write did not park the line high.");

	a_tx_bit_shift: assert property ( // see R14
		tx_step && !wr_data |=> o_txd == $past(tx_sh_r[0]) && tx_cnt_r == $past(tx_cnt_r) - 4'h1)
		else $error("Transmit bit step did not shift the frame.");

	a_tx_waits_pulse: assert property ( // see R9
		!tx_step && !wr_data |=> $stable(tx_cnt_r) && $stable(o_txd))
		else $error("Transmit line moved without a bit pulse.");

	a_stop_sets_ti: assert property (s_last_tick |=> o_txd && ti_r) // see R17
		else $error("Stop bit start did not set transmit done.");

	a_read_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00) // see R4
		else $error("Read data not zero outside a read.");

	a_read_status: assert property (rd_stat |=> o_rdata == {5'h00, $past(stat_r)}) // see R5
		else $error("Status read returned the wrong value.");

	a_stat_clear_read: assert property (rd_stat && stat_ev == 3'h0 |=> stat_r == 3'h0) // see R5
		else $error("Status read did not clear the status.");

	a_stat_sticky: assert property ( // see R5
		!rd_stat |=> (stat_r & $past(stat_r)) == $past(stat_r))
		else $error("Status bit dropped without a read.");

	a_irq_on_status: assert property (|(stat_r & mask_r) |=> o_irq) // see R5
		else $error("Interrupt low with an enabled status bit.");

	a_rx_off_quiet: assert property (s_rx_off |=> !rx_done) // see R16
		else $error("Receiver finished a frame while disabled.");

	a_mode_write: assert property (wr_ctrl |=> mode_r == $past(i_wdata[uts_pkg::B_MODE])) // see R1
		else $error("Frame length select not taken from the write.");

	a_source_write: assert property ( // see R11
		wr_tcfg |=> sel_r == $past(i_wdata[uts_pkg::B_SEL +: 3]))
		else $error("Timer source not taken from the write.");

	a_low_write: assert property (wr_low |=> bif.low == $past(i_wdata)) // see R7
		else $error("Low count write did not reach the timer.");

endmodule

// file: testbench/uts_remote.sv
/*
 * Remote serial station: sends frames into the port and decodes its transmit line.
 * Assumes 32 system clocks per bit, which a reload of 0xf0 from the system clock gives.
 */
module uts_remote #(
	parameter int BIT = 32
) (
	input wire logic i_clk,
	input wire logic i_line,
	input wire logic i_nine,
	output logic o_line,
	output logic o_got,
	output logic [9:0] o_frame
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [9:0] sh;
	int k;

	initial begin
		o_line = 1'b1;
		o_got = 1'b0;
		o_frame = 10'h000;
	end

	// The line rests high between frames; bits go out least significant first.
	task automatic send(input logic [7:0] d, input logic b9, input logic stp);
		logic [10:0] f;
		f = i_nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int i = 0; i < (i_nine ? 11 : 10); i++) begin
			o_line <= f[i];
			repeat (BIT) @(posedge i_clk);
		end
		o_line <= 1'b1;
	endtask

	// Mid-bit sampling tolerates a few cycles of phase error.
	always begin
		@(negedge i_line);
		repeat (BIT / 2) @(posedge i_clk);
		if (i_line == 1'b0) begin
			sh = 10'h000;
			for (k = 0; k < (i_nine ? 10 : 9); k++) begin
				repeat (BIT) @(posedge i_clk);
				sh = {i_line, sh[9:1]};
			end
			if (!i_nine)
				sh = {i_line, sh[9:1]};
			o_frame <= sh;
			o_got <= 1'b1;
			@(posedge i_clk);
			o_got <= 1'b0;
		end
	end
endmodule

// file: testbench/tb_top.sv
/*
 * Self-checking bench of the serial port.
 * Assumes the remote station model and a 40 MHz system clock.
 */
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic osc = 1'b0;
	logic pin = 1'b0;
	logic nine = 1'b0;
	logic rd_d = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, last_rd, b, c;
	logic rxd, txd, irq, got;
	logic [9:0] frame, fe;
	logic [15:0] re;
	logic [15:0] rd_q[$];
	logic [9:0] tx_q[$];
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int exp_t[6] = '{194, 48, 16, 4, 6, 24};

	always #12.5 clk = ~clk;

	uts_top uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd), .i_ext_osc(osc),
		.i_baud_ext_input_pin(pin), .o_irq(irq));
	uts_remote rem (.i_clk(clk), .i_line(txd), .i_nine(nine), .o_line(rxd), .o_got(got),
		.o_frame(frame));

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Read data are looked at in the one cycle they stand; frames as the station sees them.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		osc <= cyc[1];
		pin <= cyc[2];
		rd_d <= rd;
		if (rd_d) begin
			last_rd <= rdata;
			re = rd_q.pop_front();
			`CHK("rdata", re[15:8], rdata & re[7:0])
		end
		if (got) begin
			fe = tx_q.pop_front();
			`CHK("frame", fe, frame)
			`CHK("irq at stop", 1'b1, irq)
		end
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		rd_q.push_back({e & m, m});
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic send_rx(input logic [7:0] d, input logic b9, input logic stp);
		@(posedge clk);
		rem.send(d, b9, stp);
		repeat (4) @(posedge clk);
	endtask
	task automatic tx_byte(input logic [7:0] d, input logic [9:0] f);
		tx_q.push_back(f);
		wr_reg(uts_pkg::A_DATA, d);
		for (int n = 0; n < 2000 && got !== 1'b1; n++)
			@(posedge clk);
		`CHK("got", 1'b1, got)
		@(posedge clk);
	endtask

	initial begin
		void'($urandom(867));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(uts_pkg::A_CTRL, 8'h40, 8'hff);
		rd_reg(4'h7, 8'h00, 8'hff);
		rd_reg(uts_pkg::A_MASK, 8'h00, 8'hff);
		wr_reg(uts_pkg::A_RELOAD, 8'hf0);
		wr_reg(uts_pkg::A_TCFG, 8'h01);
		wr_reg(uts_pkg::A_MASK, 8'h03);
		wr_reg(uts_pkg::A_CTRL, 8'h10);
		$display("test reset done");
		b = 8'($urandom);
		c = 8'($urandom);
		// The receive start lands at an arbitrary phase of the transmit timer.
		fork
			tx_byte(c, {2'b11, c});
			begin
				repeat (7) @(posedge clk);
				send_rx(b, 1'b0, 1'b1);
			end
		join
		rd_reg(uts_pkg::A_CTRL, 8'h57, 8'hff);
		rd_reg(uts_pkg::A_DATA, b, 8'hff);
		`CHK("irq held", 1'b1, irq)
		$display("test duplex done");
		send_rx(~b, 1'b0, 1'b1);
		rd_reg(uts_pkg::A_DATA, b, 8'hff);
		rd_reg(uts_pkg::A_STAT, 8'h04, 8'h04);
		wr_reg(uts_pkg::A_CTRL, 8'h10);
		repeat (3) @(posedge clk);
		`CHK("irq clear", 1'b0, irq)
		$display("test overrun done");
		wr_reg(uts_pkg::A_CTRL, 8'h30);
		send_rx(b, 1'b0, 1'b0);
		rd_reg(uts_pkg::A_CTRL, 8'h70, 8'hff);
		send_rx(c, 1'b0, 1'b1);
		rd_reg(uts_pkg::A_CTRL, 8'h75, 8'hff);
		rd_reg(uts_pkg::A_DATA, c, 8'hff);
		$display("test stop filter done");
		nine <= 1'b1;
		wr_reg(uts_pkg::A_CTRL, 8'hb0);
		send_rx(b, 1'b0, 1'b1);
		rd_reg(uts_pkg::A_CTRL, 8'hf0, 8'hff);
		send_rx(c, 1'b1, 1'b0);
		rd_reg(uts_pkg::A_CTRL, 8'hf5, 8'hff);
		rd_reg(uts_pkg::A_DATA, c, 8'hff);
		rd_reg(uts_pkg::A_STAT, 8'h01, 8'h07);
		wr_reg(uts_pkg::A_CTRL, 8'h98);
		tx_byte(b, {2'b11, b});
		rd_reg(uts_pkg::A_CTRL, 8'hda, 8'hff);
		wr_reg(uts_pkg::A_CTRL, 8'h90);
		tx_byte(c, {2'b10, c});
		$display("test nine bit done");
		// Each source runs the count for a fixed stretch; a small tolerance absorbs phase.
		for (int s = 0; s < 6; s++) begin
			wr_reg(uts_pkg::A_RELOAD, 8'h00);
			wr_reg(uts_pkg::A_LOW, 8'h00);
			wr_reg(uts_pkg::A_TCFG, 8'(s * 2 + 1));
			repeat (192) @(posedge clk);
			wr_reg(uts_pkg::A_TCFG, 8'(s * 2));
			rd_reg(uts_pkg::A_LOW, 8'h00, 8'h00);
			@(posedge clk);
			`CHK("ticks", 1'b1, (last_rd + 3 >= exp_t[s]) && (last_rd <= exp_t[s] + 3))
		end
		$display("test clock sources done");
		conclude();
	end
endmodule
